// >>> pkg/arc_pkg.sv
package arc_pkg;
    // number of initiating sources: 12 protective elements plus the binary input
    localparam int unsigned NSRC       = 13;
    localparam int unsigned BIN_SRC    = 12;          // index of the binary trip input
    localparam int unsigned SHOT_W     = 4;           // shot counts 0..9
    localparam logic [3:0]  MAX_SHOTS  = 4'h9;
    localparam logic [3:0]  LAST_OWN_DT = 4'h4;       // shots above this reuse dead time 4
    localparam int unsigned TMR_W      = 16;          // timer width in ticks
    // tick period: one enable per 50 us; keeps runs short, but caps
    // 16-bit timers at about 3.3 s
    localparam int unsigned TICK_NS    = 50000;
    localparam int unsigned CLK_NS     = 25;
    localparam int unsigned TICK_CYC   = TICK_NS / CLK_NS;
    localparam int unsigned TICK_W     = 16;
    // per-source mode codes
    localparam logic [1:0]  SRC_IGNORE   = 2'h0;
    localparam logic [1:0]  SRC_INITIATE = 2'h1;
    localparam logic [1:0]  SRC_BLOCK    = 2'h2;
    // sequencer states, one-hot
    typedef enum logic [5:0] {
        ARC_IDLE  = 6'h01,
        ARC_WOPEN = 6'h02,
        ARC_DEAD  = 6'h04,
        ARC_RECL  = 6'h08,
        ARC_WTRIP = 6'h10,
        ARC_DYN   = 6'h20
    } arc_state_t;
endpackage : arc_pkg

// >>> rtl/arc_timer.sv
// down-counting tick timer; load wins over count
module arc_timer (
    input  wire logic                          sys_clk,
    input  wire logic                          nrst,
    input  wire logic                          srst,     // synchronous clear
    input  wire logic                          load,     // start with new value
    input  wire logic                          stop,     // abandon count
    input  wire logic                          tick,     // one-cycle time base
    input  wire logic [arc_pkg::TMR_W-1:0]     value,
    output logic                               running,
    output logic                               expired   // one-cycle pulse
);
    logic [arc_pkg::TMR_W-1:0] cnt_reg;   // ticks still to go

    // counter; a zero load expires at the next tick
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            cnt_reg <= '0;
            running <= 1'b0;
            expired <= 1'b0;
        end
        else if (srst || stop)
        begin
            cnt_reg <= '0;
            running <= 1'b0;
            expired <= 1'b0;
        end
        else if (load)
        begin
            cnt_reg <= value;
            running <= 1'b1;
            expired <= 1'b0;
        end
        else if (running && tick)
        begin
            if (cnt_reg <= arc_pkg::TMR_W'(1))
            begin
                cnt_reg <= '0;
                running <= 1'b0;
                expired <= 1'b1;
            end
            else
            begin
                cnt_reg <= cnt_reg - arc_pkg::TMR_W'(1);
                expired <= 1'b0;
            end
        end
        else
        begin
            expired <= 1'b0;
        end
    end
endmodule : arc_timer

// >>> rtl/arc_seq.sv
// Notes on behaviour
// - shot counts zero to nine per program
// - ground program for single phase/ground pickups
// - phase program for multi-phase or other sources
// - program fixed before first reclose, kept after
// - four dead times, shots five-nine reuse fourth
// - dead time starts on open, then close
// - blocking timer starts with each close
// - blocking expiry returns idle, shots cleared
// - trip during blocking runs next shot
// - trip after last shot: dynamic block
// - fault after blocking expiry starts fresh
// - per-source initiate, ignore or block
// - external block input blocks statically when idle
// - breaker not ready blocks statically when idle
// - both shot counts zero blocks statically
// - no initiating source blocks statically
// - static block indication while condition persists
// - static block output disables dependent elements
// - binary trip input initiates like elements
// - dynamic block until closed and timer elapsed
module arc_seq (
    input  wire logic                          sys_clk,
    input  wire logic                          nrst,
    input  wire logic                          srst,            // synchronous reset
    // pickup of each source; [11:0] elements, [12] binary trip input
    input  wire logic [arc_pkg::NSRC-1:0]      src_pickup,
    input  wire logic [arc_pkg::NSRC-1:0]      src_is_ground,   // source is ground-path
    input  wire logic [arc_pkg::NSRC-1:0]      src_phase_a,     // source tied to phase a
    input  wire logic [arc_pkg::NSRC-1:0]      src_phase_b,
    input  wire logic [arc_pkg::NSRC-1:0]      src_phase_c,
    input  wire logic [2*arc_pkg::NSRC-1:0]    src_mode,        // two bits per source
    input  wire logic                          gnd_prog_input,  // binary start of ground prog
    input  wire logic                          trip,            // any protective trip
    input  wire logic                          pin_breaker_open, // breaker open pin
    input  wire logic                          pin_ext_block,   // external block pin
    input  wire logic                          pin_breaker_ready_input,
    input  wire logic                          bf_init,         // breaker-failure initiation
    input  wire logic [3:0]                    shots_phase,
    input  wire logic [3:0]                    shots_ground,
    input  wire logic [4*arc_pkg::TMR_W-1:0]   dead_phase,      // dead times 1..4
    input  wire logic [4*arc_pkg::TMR_W-1:0]   dead_ground,
    input  wire logic [arc_pkg::TMR_W-1:0]     block_time,
    input  wire logic [arc_pkg::TMR_W-1:0]     dyn_block_time,
    output logic                               close_cmd,       // one-cycle close pulse
    output logic                               static_block,    // indication and element gate
    output logic                               dyn_block,
    output logic                               seq_active,
    output logic                               prog_ground,     // 1 ground, 0 phase program
    output logic [3:0]                         shot_count
);
    arc_pkg::arc_state_t state_reg;
    arc_pkg::arc_state_t state_next;

    // synchronisers for pins: three flops, change when 2nd and 3rd agree
    logic [2:0] open_sy;
    logic [2:0] blk_sy;
    logic [2:0] rdy_sy;
    logic       open_reg;
    logic       blk_reg;
    logic       rdy_reg;

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            open_sy  <= 3'h0;
            blk_sy   <= 3'h0;
            rdy_sy   <= 3'h0;
            open_reg <= 1'b0;
            blk_reg  <= 1'b0;
            rdy_reg  <= 1'b0;
        end
        else
        begin
            open_sy <= {open_sy[1:0], pin_breaker_open};
            blk_sy  <= {blk_sy[1:0], pin_ext_block};
            rdy_sy  <= {rdy_sy[1:0], pin_breaker_ready_input};
            // glitch filter only looks at stages two and three
            if (open_sy[1] == open_sy[2])
                open_reg <= open_sy[2];
            if (blk_sy[1] == blk_sy[2])
                blk_reg <= blk_sy[2];
            if (rdy_sy[1] == rdy_sy[2])
                rdy_reg <= rdy_sy[2];
        end
    end

    // tick divider; every timer counts this enable
    logic [arc_pkg::TICK_W-1:0] div_reg;
    logic                       tick;

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            div_reg <= '0;
            tick    <= 1'b0;
        end
        else if (srst)
        begin
            div_reg <= '0;
            tick    <= 1'b0;
        end
        else if (div_reg == arc_pkg::TICK_W'(arc_pkg::TICK_CYC - 1))
        begin
            div_reg <= '0;
            tick    <= 1'b1;
        end
        else
        begin
            div_reg <= div_reg + arc_pkg::TICK_W'(1);
            tick    <= 1'b0;
        end
    end

    // source classification
    logic [arc_pkg::NSRC-1:0] init_en;    // sources set to initiate
    logic [arc_pkg::NSRC-1:0] block_en;   // sources set to block
    logic                     init_hit;
    logic                     block_hit;
    logic                     ground_kind;
    logic [1:0]               phase_sum;
    logic                     other_hit;

    always_comb
    begin
        for (int i = 0; i < arc_pkg::NSRC; i++)
        begin
            init_en[i]  = (src_mode[2*i +: 2] == arc_pkg::SRC_INITIATE);
            block_en[i] = (src_mode[2*i +: 2] == arc_pkg::SRC_BLOCK);
        end
    end

    logic [arc_pkg::NSRC-1:0] act;
    assign act       = src_pickup & init_en;
    // binary input counts like any element
    assign init_hit  = |act;
    assign block_hit = |(src_pickup & block_en);
    assign phase_sum = 2'(|(act & src_phase_a)) + 2'(|(act & src_phase_b))
                     + 2'(|(act & src_phase_c));
    // an element pickup tied to no phase and no ground (e.g. negative sequence)
    assign other_hit = |(act & ~src_is_ground & ~src_phase_a & ~src_phase_b & ~src_phase_c
                       & ~(arc_pkg::NSRC'(1) << arc_pkg::BIN_SRC));
    // ground: at most one phase, no other-kind, or the dedicated input
    assign ground_kind = gnd_prog_input
                       || ((phase_sum <= 2'h1) && !other_hit);

    // static block conditions
    logic static_cond;
    assign static_cond = (state_reg == arc_pkg::ARC_IDLE && (blk_reg || !rdy_reg))
                       || (shots_phase == 4'h0 && shots_ground == 4'h0)
                       || (init_en == '0);
    assign static_block = static_cond;

    // program and shot bookkeeping
    logic       prog_reg;
    logic [3:0] shot_reg;
    logic [3:0] shot_lim;
    logic [1:0] dt_idx;
    logic [arc_pkg::TMR_W-1:0] dead_val;

    // limit clipped at nine
    always_comb
    begin
        shot_lim = prog_reg ? shots_ground : shots_phase;
        if (shot_lim > arc_pkg::MAX_SHOTS)
        begin
            shot_lim = arc_pkg::MAX_SHOTS;
        end
    end

    // dead time selection; shots beyond four use the fourth
    assign dt_idx   = (shot_reg >= (arc_pkg::LAST_OWN_DT - 4'h1)) ? 2'h3 : shot_reg[1:0];
    assign dead_val = prog_reg ? dead_ground[arc_pkg::TMR_W*dt_idx +: arc_pkg::TMR_W]
                               : dead_phase[arc_pkg::TMR_W*dt_idx +: arc_pkg::TMR_W];

    // timers
    logic dead_load, blk_load, dyn_load, dead_run, blk_run, dyn_run;
    logic dead_exp, blk_exp, dyn_exp;

    arc_timer u_dead (
        .sys_clk (sys_clk), .nrst (nrst), .srst (srst), .load (dead_load),
        .stop    (state_next != arc_pkg::ARC_DEAD && state_reg == arc_pkg::ARC_DEAD),
        .tick    (tick), .value (dead_val), .running (dead_run), .expired (dead_exp)
    );
    arc_timer u_block (
        .sys_clk (sys_clk), .nrst (nrst), .srst (srst), .load (blk_load),
        .stop    (state_reg == arc_pkg::ARC_WTRIP && trip),
        .tick    (tick), .value (block_time), .running (blk_run), .expired (blk_exp)
    );
    arc_timer u_dyn (
        .sys_clk (sys_clk), .nrst (nrst), .srst (srst), .load (dyn_load),
        .stop    (state_reg == arc_pkg::ARC_DYN && (open_reg || bf_init)),
        .tick    (tick), .value (dyn_block_time), .running (dyn_run), .expired (dyn_exp)
    );

    // next-state logic
    always_comb
    begin
        state_next = state_reg;
        dead_load  = 1'b0;
        blk_load   = 1'b0;
        dyn_load   = 1'b0;
        case (state_reg)
            arc_pkg::ARC_IDLE:
            begin
                if (bf_init || (block_hit && !static_cond))
                    state_next = arc_pkg::ARC_DYN;
                else if (trip && init_hit && !static_cond)
                    state_next = arc_pkg::ARC_WOPEN;
            end
            arc_pkg::ARC_WOPEN:
            begin
                if (bf_init || block_hit || shot_lim == 4'h0)
                    state_next = arc_pkg::ARC_DYN;
                else if (open_reg)
                begin
                    state_next = arc_pkg::ARC_DEAD;
                    dead_load  = 1'b1;
                end
            end
            arc_pkg::ARC_DEAD:
            begin
                if (bf_init || block_hit)
                    state_next = arc_pkg::ARC_DYN;
                else if (dead_exp)
                begin
                    state_next = arc_pkg::ARC_WTRIP;
                    blk_load   = 1'b1;
                end
            end
            arc_pkg::ARC_WTRIP:
            begin
                if (bf_init || block_hit)
                    state_next = arc_pkg::ARC_DYN;
                else if (trip && shot_reg < shot_lim)
                    state_next = arc_pkg::ARC_WOPEN;
                else if (trip)
                    state_next = arc_pkg::ARC_DYN;
                else if (blk_exp)
                    state_next = arc_pkg::ARC_IDLE;
            end
            arc_pkg::ARC_DYN:
            begin
                // timer stops while breaker open, restarts once closed; closed and elapsed releases
                if (!open_reg && !dyn_run && !bf_init && !dyn_exp)
                    dyn_load = 1'b1;
                if (dyn_exp && !open_reg)
                    state_next = arc_pkg::ARC_IDLE;
            end
            default:
                state_next = arc_pkg::ARC_IDLE;
        endcase
    end

    // state register
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            state_reg <= arc_pkg::ARC_IDLE;
        else if (srst)
            state_reg <= arc_pkg::ARC_IDLE;
        else
            state_reg <= state_next;
    end

    // program choice: only before the first reclose
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            prog_reg <= 1'b0;
        else if (srst)
            prog_reg <= 1'b0;
        else if (shot_reg == 4'h0 && state_reg != arc_pkg::ARC_WTRIP
                 && state_reg != arc_pkg::ARC_DYN && init_hit)
            prog_reg <= ground_kind;
    end

    // shot counter and close pulse
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            shot_reg  <= 4'h0;
            close_cmd <= 1'b0;
        end
        else if (srst)
        begin
            shot_reg  <= 4'h0;
            close_cmd <= 1'b0;
        end
        else
        begin
            close_cmd <= blk_load;
            if (blk_load)
            begin
                shot_reg <= shot_reg + 4'h1;
            end
            else if (state_next == arc_pkg::ARC_IDLE)
            begin
                shot_reg <= 4'h0;
            end
        end
    end

    assign dyn_block   = (state_reg == arc_pkg::ARC_DYN);
    assign seq_active  = (state_reg != arc_pkg::ARC_IDLE) && !dyn_block;
    assign prog_ground = prog_reg;
    assign shot_count  = shot_reg;

    // close only follows an expired dead time
    close_after_dead_a: assert property (@(posedge sys_clk) disable iff (!nrst || srst)
        close_cmd |-> $past(dead_exp) && $past(state_reg) == arc_pkg::ARC_DEAD)
        else $error("close without dead time");
    // blocking timer runs right after a close
    block_with_close_a: assert property (@(posedge sys_clk) disable iff (!nrst || srst)
        close_cmd |-> blk_run)
        else $error("blocking timer not started");
    // expiry without trip returns idle with zero shots
    idle_on_expiry_a: assert property (@(posedge sys_clk) disable iff (!nrst || srst)
        (state_reg == arc_pkg::ARC_WTRIP && blk_exp && !trip && !bf_init && !block_hit)
        |=> state_reg == arc_pkg::ARC_IDLE && shot_reg == 4'h0)
        else $error("no return to idle");
    // trip with shots left continues the sequence
    next_shot_a: assert property (@(posedge sys_clk) disable iff (!nrst || srst)
        (state_reg == arc_pkg::ARC_WTRIP && trip && !bf_init && !block_hit
         && shot_reg < shot_lim) |=> state_reg == arc_pkg::ARC_WOPEN && !blk_run)
        else $error("next shot missed");
    // trip after last shot locks out
    final_trip_a: assert property (@(posedge sys_clk) disable iff (!nrst || srst)
        (state_reg == arc_pkg::ARC_WTRIP && trip && shot_reg >= shot_lim)
        |=> dyn_block)
        else $error("no lockout after final shot");
    // shot count never exceeds nine
    shot_bound_a: assert property (@(posedge sys_clk) disable iff (!nrst || srst)
        shot_count <= arc_pkg::MAX_SHOTS)
        else $error("shot count above nine");
    // statically blocked idle never starts
    static_hold_a: assert property (@(posedge sys_clk) disable iff (!nrst || srst)
        (state_reg == arc_pkg::ARC_IDLE && static_block && !bf_init)
        |=> state_reg == arc_pkg::ARC_IDLE)
        else $error("start while statically blocked");
    // zero shot counts block and keep an idle sequencer from starting
    zero_shots_a: assert property (@(posedge sys_clk) disable iff (!nrst || srst)
        (shots_phase == 4'h0 && shots_ground == 4'h0 && state_reg == arc_pkg::ARC_IDLE
         && !bf_init) |-> static_block ##1 state_reg == arc_pkg::ARC_IDLE)
        else $error("zero shots not blocked");
    // program stays put once closing has begun
    prog_stable_a: assert property (@(posedge sys_clk) disable iff (!nrst || srst)
        (shot_reg != 4'h0 && $past(shot_reg) != 4'h0) |-> $stable(prog_reg))
        else $error("program changed mid sequence");
endmodule : arc_seq

// >>> tb/arc_brk_model.sv
// breaker mechanism plus ready contact seen from the sequencer
module arc_brk_model (
    input  wire logic sys_clk,
    input  wire logic nrst,
    input  wire logic trip,       // protective trip coil
    input  wire logic close_cmd,  // auto close coil
    input  wire logic man_close,  // operator close
    input  wire logic ready_en,   // mechanism charged
    output logic      brk_open,   // auxiliary contact, open state
    output logic      brk_ready   // ready contact
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [3:0] dly_reg;  // travel time left
    logic       shut_reg; // pending move goes to closed
    // moves take eight cycles; commands during a move are lost, like a real mechanism
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            brk_open <= 1'b0;
            dly_reg  <= 4'h0;
            shut_reg <= 1'b0;
        end
        else if (dly_reg != 4'h0)
        begin
            dly_reg <= dly_reg - 4'h1;
            if (dly_reg == 4'h1)
                brk_open <= !shut_reg;
        end
        else if (trip && !brk_open)
        begin
            dly_reg  <= 4'h8;
            shut_reg <= 1'b0;
        end
        else if ((close_cmd || man_close) && brk_open)
        begin
            dly_reg  <= 4'h8;
            shut_reg <= 1'b1;
        end
    end
    // ready contact follows the charge state only
    assign brk_ready = ready_en;
endmodule : arc_brk_model

// >>> tb/tb.sv
// sequencer bench: faults are driven as trip plus pickup, breaker is modelled
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int TK = arc_pkg::TICK_CYC;           // cycles per tick
    localparam logic [25:0] MODE_ON  = 26'h1000025;  // 0,1,12 start, 2 blocks
    localparam logic [25:0] MODE_OFF = 26'h0000020;  // nothing starts
    logic        sys_clk = 1'b0;
    logic        nrst    = 1'b0;
    logic        trip    = 1'b0;
    logic        bf_init = 1'b0;
    logic        ext_blk = 1'b0;
    logic        rdy_en  = 1'b1;
    logic        man_cl  = 1'b0;
    logic        gnd_in  = 1'b0;
    logic        srst    = 1'b0;
    logic [12:0] gnd_cls = '0;                       // ground-path sources
    logic [63:0] dead_gn = {4{16'h0001}};            // ground program dead times
    logic [15:0] blk_t   = 16'h0003;                 // blocking time, well over one tick
    logic [12:0] pick    = '0;
    logic [25:0] mode    = MODE_ON;
    logic [3:0]  sh_ph   = 4'h2;
    logic [3:0]  sh_gn   = 4'h1;
    logic        close_cmd, static_block, dyn_block, seq_active, prog_ground;
    logic        brk_open, brk_ready;
    logic [3:0]  shot_count;
    int          error_cnt = 0;
    int          cmp_count = 0;
    int          close_n   = 0;                      // close pulses seen
    longint      cyc       = 0;
    longint      t_open;                             // cycle breaker seen open
    int          k;
    // clock, 25 ns period
    always #12.5 sys_clk = ~sys_clk;
    // count pulses mid-cycle where the registered output is settled
    always @(negedge sys_clk)
    begin
        cyc++;
        if (close_cmd === 1'b1)
            close_n++;
    end
    arc_seq i_arc_seq (
        .sys_clk(sys_clk), .nrst(nrst), .srst(srst), .src_pickup(pick),
        .src_is_ground(gnd_cls), .src_phase_a(13'h0001), .src_phase_b(13'h0002),
        .src_phase_c(13'h0000), .src_mode(mode), .gnd_prog_input(gnd_in),
        .trip(trip), .pin_breaker_open(brk_open), .pin_ext_block(ext_blk),
        .pin_breaker_ready_input(brk_ready), .bf_init(bf_init),
        .shots_phase(sh_ph), .shots_ground(sh_gn),
        .dead_phase({16'h0001, 16'h0001, 16'h0003, 16'h0001}),
        .dead_ground(dead_gn), .block_time(blk_t),
        .dyn_block_time(16'h0002), .close_cmd(close_cmd),
        .static_block(static_block), .dyn_block(dyn_block),
        .seq_active(seq_active), .prog_ground(prog_ground), .shot_count(shot_count));
    arc_brk_model i_arc_brk_model (
        .sys_clk(sys_clk), .nrst(nrst), .trip(trip), .close_cmd(close_cmd),
        .man_close(man_cl), .ready_en(rdy_en), .brk_open(brk_open),
        .brk_ready(brk_ready));
    // verdict, reached from the main sequence or the watchdog
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : wrap_up
    // single-bit result
    task automatic chk_bit(input string nm, input logic exp, input logic got);
        cmp_count++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("mismatch %s expected %b seen %b", nm, exp, got);
        end
    endtask : chk_bit
    // shot counter result
    task automatic chk_cnt(input string nm, input logic [3:0] exp, input logic [3:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk_cnt
    // trip with pickups until the breaker opens, then the fault clears
    task automatic fault(input logic [12:0] pk);
        int i;
        @(negedge sys_clk);
        pick = pk;
        trip = 1'b1;
        for (i = 0; i < 200 && brk_open !== 1'b1; i++)
            @(negedge sys_clk);
        t_open = cyc;
        @(negedge sys_clk);
        pick = '0;
        trip = 1'b0;
    endtask : fault
    // breaker travel plus pin synchroniser, so a later trip meets a shut breaker
    task automatic wait_shut;
        int i;
        for (i = 0; i < 50 && brk_open !== 1'b0; i++)
            @(negedge sys_clk);
        repeat (6) @(negedge sys_clk);
    endtask : wait_shut
    // bounded wait for the next close pulse and the breaker shutting
    task automatic wait_close;
        int i;
        int n0;
        n0 = close_n;
        for (i = 0; i < 6 * TK && close_n == n0; i++)
            @(negedge sys_clk);
        wait_shut();
    endtask : wait_close
    // bounded wait for a quiet, unblocked sequencer
    task automatic wait_idle;
        int i;
        for (i = 0; i < 5 * TK && (seq_active !== 1'b0 || dyn_block !== 1'b0); i++)
            @(negedge sys_clk);
    endtask : wait_idle
    // operator closes the breaker after a lockout
    task automatic recover;
        @(negedge sys_clk);
        man_cl = 1'b1;
        @(negedge sys_clk);
        man_cl = 1'b0;
        wait_shut();
        wait_idle();
    endtask : recover
    // main sequence
    initial
    begin
        repeat (16) @(negedge sys_clk);
        nrst = 1'b1;
        repeat (8) @(negedge sys_clk);
        // each static condition alone, then none
        for (k = 0; k < 5; k++)
        begin
            ext_blk = (k == 0);
            rdy_en  = (k != 1);
            sh_ph   = (k == 2) ? 4'h0 : 4'h2;
            sh_gn   = (k == 2) ? 4'h0 : 4'h1;
            mode    = (k == 3) ? MODE_OFF : MODE_ON;
            repeat (8) @(negedge sys_clk);
            chk_bit("static_block", k < 4, static_block);
        end
        // single-phase fault, one shot, reclose holds
        fault(13'h0001);
        wait_close();
        chk_bit("prog_ground", 1'b1, prog_ground);
        chk_cnt("shot_count", 4'h1, shot_count);
        wait_idle();
        chk_bit("seq_active", 1'b0, seq_active);
        chk_cnt("shot_count", 4'h0, shot_count);
        // two-phase fault: new program, retrip in blocking, lockout
        fault(13'h0003);
        wait_close();
        chk_bit("prog_ground", 1'b0, prog_ground);
        fault(13'h0003);
        wait_close();
        chk_cnt("shot_count", 4'h2, shot_count);
        chk_bit("dead_time_two", 1'b1, (cyc - t_open) >= 2 * TK);
        k = close_n;
        fault(13'h0003);
        repeat (3 * TK) @(negedge sys_clk);
        chk_bit("no_close", 1'b1, close_n == k);
        chk_bit("dyn_block", 1'b1, dyn_block);
        recover();
        chk_bit("dyn_block", 1'b0, dyn_block);
        // binary trip input with ground program request
        // ground program carries its own first dead time
        gnd_in        = 1'b1;
        dead_gn[15:0] = 16'h0003;
        fault(13'h1000);
        wait_close();
        gnd_in = 1'b0;
        chk_bit("prog_ground", 1'b1, prog_ground);
        chk_bit("dead_time_gnd", 1'b1, (cyc - t_open) >= 2 * TK);
        wait_idle();
        // pickup kind picks the program; a synchronous reset aborts the run
        mode = 26'h1000015;
        for (k = 0; k < 3; k++)
        begin
            gnd_cls = (k == 1) ? 13'h0004 : 13'h0000;
            gnd_in  = (k == 2);
            fault(13'h0005);
            chk_bit("prog_ground", k != 0, prog_ground);
            srst = 1'b1;
            @(negedge sys_clk);
            srst = 1'b0;
            @(negedge sys_clk);
            chk_bit("seq_active", 1'b0, seq_active);
            chk_bit("prog_ground", 1'b0, prog_ground);
            recover();
        end
        gnd_in = 1'b0;
        mode   = MODE_ON;
        // blocking source locks out
        fault(13'h0004);
        repeat (20) @(negedge sys_clk);
        chk_bit("dyn_block", 1'b1, dyn_block);
        recover();
        // breaker failure initiation locks out
        bf_init = 1'b1;
        repeat (2) @(negedge sys_clk);
        bf_init = 1'b0;
        repeat (10) @(negedge sys_clk);
        chk_bit("dyn_block", 1'b1, dyn_block);
        wait_idle();
        chk_bit("dyn_block", 1'b0, dyn_block);
        wrap_up();
    end
    // watchdog, well beyond the roughly twenty-five ticks the tests need
    initial
    begin
        repeat (40 * TK) @(negedge sys_clk);
        error_cnt++;
        wrap_up();
    end
endmodule : tb
